// >>> dv/mfp_far_side.sv
`timescale 1ns/100ps
// ==============================
// Hall sensors and controller model
module mfp_far_side (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic step_i,
  input wire logic back_i,
  input wire logic bad_i,
  input wire logic bad_hi_i,
  input wire logic fault_out_i,
  input wire logic [5:0] demand_i,
  output logic hall_pos_u_o,
  output logic hall_pos_v_o,
  output logic hall_pos_w_o,
  output logic [5:0] sine_gates_o
);
  // Legal codes in forward order
  localparam logic [2:0] SEQ [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
  logic [2:0] idx;
  wire logic [2:0] code = bad_i ? {3{bad_hi_i}} : SEQ[idx];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx <= 3'h0;
    end else if (step_i && back_i) begin
      idx <= (idx == 3'h0) ? 3'h5 : idx - 3'h1;
    end else if (step_i) begin
      idx <= (idx == 3'h5) ? 3'h0 : idx + 3'h1;
    end
  end
  assign {hall_pos_u_o, hall_pos_v_o, hall_pos_w_o} = code;
  // Restart pause after a fault, scaled far below the real two seconds
  localparam logic [7:0] RESTART_PAUSE = 8'h01;
  logic [7:0] pause;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pause <= 8'h00;
    end else if (fault_out_i) begin
      pause <= RESTART_PAUSE;
    end else if (pause != 8'h00) begin
      pause <= pause - 8'h01;
    end
  end
  // Demands dropped at once on fault
  assign sine_gates_o = (fault_out_i || pause != 8'h00) ? 6'h00 : demand_i;
endmodule

// >>> dv/motor_fault_protection_bench.sv
`timescale 1ns/100ps
// ==============================
// Bench top
module motor_fault_protection_bench;
  import mfp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic lim = 1'b0, trip = 1'b0, hot = 1'b0, cool = 1'b1, dir = 1'b0, pwm = 1'b0;
  logic step = 1'b0, back = 1'b0, bad = 1'b0, bad_hi = 1'b0;
  logic [5:0] demand = 6'h00, sine, gates;
  logic hu, hv, hw, trap, fault;
  wire logic [2:0] hc = {hu, hv, hw};
  int bad_count = 0;
  int checks_done = 0;
  logic [7:0] oq [$];
  logic [31:0] rq [$];
  event take;

  mfp_top #(.LIMIT_BLANK_CYC(23), .TRIP_BLANK_CYC(8), .TRIP_HOLD_CYC(20), .LOCK_DETECT_CYC(30),
    .LOCK_HOLD_CYC(40)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .limit_threshold_i(lim), .trip_threshold_i(trip), .thermal_trip_temp_i(hot),
    .thermal_hysteresis_i(cool), .hall_pos_u_i(hu), .hall_pos_v_i(hv), .hall_pos_w_i(hw),
    .direction_select_i(dir), .pwm_period_start_i(pwm), .sine_gates_i(sine), .gates_o(gates),
    .trapezoidal_o(trap), .fault_out_o(fault));
  mfp_far_side far (.clk_i(clk_i), .rst_i(rst_i), .step_i(step), .back_i(back), .bad_i(bad),
    .bad_hi_i(bad_hi), .fault_out_i(fault), .demand_i(demand), .hall_pos_u_o(hu),
    .hall_pos_v_o(hv), .hall_pos_w_o(hw), .sine_gates_o(sine));

  always #50 clk_i = ~clk_i;

  // ==============================
  // Tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic cmp_bus(input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("BAD read data expected %h seen %h", e, s);
    end
  endtask
  task automatic cmp_out(input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("BAD gates fault trap expected %h seen %h", e, s);
    end
  endtask
  // Request held until ack is seen; no latency assumed
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic expect_out(input logic [5:0] g, input logic f, input logic t);
    @(negedge clk_i);
    oq.push_back({g, f, t});
    -> take;
    @(posedge clk_i);
  endtask
  task automatic step_one(input logic b);
    @(posedge clk_i);
    demand <= 6'($urandom);
    back <= b;
    step <= 1'b1;
    @(posedge clk_i);
    step <= 1'b0;
    tick(8);
  endtask
  function automatic logic [5:0] ftab(input logic [2:0] c);
    case (c)
      3'h5: ftab = 6'h18;
      3'h4: ftab = 6'h12;
      3'h6: ftab = 6'h06;
      3'h2: ftab = 6'h24;
      3'h3: ftab = 6'h21;
      3'h1: ftab = 6'h09;
      default: ftab = 6'h00;
    endcase
  endfunction
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==============================
  // Monitors
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0 && rq.size() > 0) begin
      cmp_bus(rq.pop_front(), rdat);
    end
  end
  always @(take) begin
    cmp_out(oq.pop_front(), {gates, fault, trap});
  end
  initial begin
    #(100 * 20000);
    bad_count++;
    end_of_test();
  end

  // ==============================
  // Main sequence
  initial begin
    int n;
    void'($urandom(24));
    tick(8);
    rst_i <= 1'b0;
    rd(8'h00, 32'h2);
    wb(1'b1, 8'h00, 32'hffff_fffd);
    rd(8'h00, 32'h1);
    wb(1'b1, 8'h08, 32'hffff_ffff);
    rd(8'h08, 32'h0);
    wb(1'b1, 8'h00, 32'h0);
    // All direction and rotation pairings, every code
    for (int d = 0; d < 2; d++) begin
      dir <= d[0];
      for (int r = 0; r < 2; r++) begin
        for (int k = 0; k < 6; k++) begin
          step_one(r[0]);
          expect_out(d == r ? demand : ftab(d[0] ? ~hc : hc), 1'(d != r), 1'(d != r));
        end
      end
    end
    dir <= 1'b0;
    step_one(1'b0);
    expect_out(demand, 1'b0, 1'b0);
    for (int b = 0; b < 2; b++) begin
      @(posedge clk_i);
      bad <= 1'b1;
      bad_hi <= b[0];
      tick(6);
      expect_out(6'h00, 1'b1, 1'b0);
      tick(20);
      expect_out(6'h00, 1'b1, 1'b0);
      @(posedge clk_i);
      bad <= 1'b0;
      tick(6);
      expect_out(demand, 1'b0, 1'b0);
    end
    // Short excursions stay below the blanking counts
    @(posedge clk_i);
    lim <= 1'b1;
    trip <= 1'b1;
    tick(5);
    trip <= 1'b0;
    tick(5);
    lim <= 1'b0;
    tick(6);
    expect_out(demand, 1'b0, 1'b0);
    lim <= 1'b1;
    tick(30);
    lim <= 1'b0;
    tick(6);
    expect_out(6'h00, 1'b0, 1'b0);
    rd(8'h04, 32'h01);
    pwm <= 1'b1;
    @(posedge clk_i);
    pwm <= 1'b0;
    tick(4);
    expect_out(demand, 1'b0, 1'b0);
    trip <= 1'b1;
    tick(14);
    trip <= 1'b0;
    expect_out(6'h00, 1'b1, 1'b0);
    rd(8'h04, 32'h82);
    tick(10);
    expect_out(6'h00, 1'b1, 1'b0);
    tick(15);
    expect_out(demand, 1'b0, 1'b0);
    hot <= 1'b1;
    cool <= 1'b0;
    tick(6);
    expect_out(6'h00, 1'b1, 1'b0);
    hot <= 1'b0;
    tick(6);
    expect_out(6'h00, 1'b1, 1'b0);
    cool <= 1'b1;
    tick(8);
    expect_out(demand, 1'b0, 1'b0);
    // Hall held still with lock detect on
    wb(1'b1, 8'h00, 32'h2);
    for (n = 0; n < 80 && fault !== 1'b1; n++) begin
      @(posedge clk_i);
    end
    expect_out(6'h00, 1'b1, 1'b0);
    rd(8'h04, 32'h88);
    tick(30);
    expect_out(6'h00, 1'b1, 1'b0);
    tick(15);
    expect_out(demand, 1'b0, 1'b0);
    wb(1'b1, 8'h00, 32'h0);
    tick(4);
    end_of_test();
  end
endmodule

// >>> hdl/mfp_pkg.sv
package mfp_pkg;
  typedef enum logic [1:0] {
    MFP_RUN,
    MFP_TRIP_HOLD,
    MFP_LOCK_HOLD
  } mfp_state_type;
  typedef logic [5:0] mfp_gates_type;
endpackage

// >>> hdl/mfp_regs.svh
`ifndef MFP_REGS_SVH
`define MFP_REGS_SVH
// Clock rate in kHz
`define MFP_CLK_KHZ 10000
// Register map, byte addresses
`define MFP_CTRL_ADDR 8'h00
`define MFP_STAT_ADDR 8'h04
// Control fields and reset value
`define MFP_CTRL_DIR_BIT 0
`define MFP_CTRL_LOCK_EN_BIT 1
`define MFP_CTRL_RESET 32'h0000_0002
// Status field positions
`define MFP_ST_LIMIT_BIT 0
`define MFP_ST_TRIP_BIT 1
`define MFP_ST_THERM_BIT 2
`define MFP_ST_LOCK_BIT 3
`define MFP_ST_REV_BIT 4
`define MFP_ST_HALL_BIT 5
`define MFP_ST_TRAP_BIT 6
`define MFP_ST_FAULT_BIT 7
// Times in their own units, counts derived
`define MFP_LIMIT_BLANK_NS 2300
`define MFP_TRIP_BLANK_NS 800
`define MFP_TRIP_HOLD_MS 15
`define MFP_LOCK_DETECT_S 5
`define MFP_LOCK_HOLD_S 64
`define MFP_LIMIT_BLANK_CYC ((`MFP_LIMIT_BLANK_NS * `MFP_CLK_KHZ + 999999) / 1000000)
`define MFP_TRIP_BLANK_CYC ((`MFP_TRIP_BLANK_NS * `MFP_CLK_KHZ + 999999) / 1000000)
`define MFP_TRIP_HOLD_CYC (`MFP_TRIP_HOLD_MS * `MFP_CLK_KHZ)
`define MFP_LOCK_DETECT_CYC (`MFP_LOCK_DETECT_S * `MFP_CLK_KHZ * 1000)
`define MFP_LOCK_HOLD_CYC (`MFP_LOCK_HOLD_S * `MFP_CLK_KHZ * 1000)
`endif

// >>> hdl/mfp_sync.sv
`timescale 1ns/100ps
module mfp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;
  // Only the second stage is seen by logic
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          stage1[g] <= 1'b0;
          sync_o[g] <= 1'b0;
        end else begin
          stage1[g] <= async_i[g];
          sync_o[g] <= stage1[g];
        end
      end
    end
  endgenerate
endmodule

// >>> hdl/mfp_timer.sv
`timescale 1ns/100ps
module mfp_timer #(
  parameter int WIDTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [WIDTH-1:0] limit_i,
  output logic done_o
);
  logic [WIDTH-1:0] count;
  // Saturating count; clears when run drops
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      count <= '0;
    end else if (count != limit_i) begin
      count <= count + 1'b1;
    end
  end
  assign done_o = run_i && (count == limit_i);
endmodule

// >>> hdl/mfp_top.sv
// Function
// - Sense at or above limit threshold for limit blanking time turns all switches off
// - Current limit shutoff clears at start of every PWM period unless limit blanking is done in that cycle
// - Sense at or above trip threshold for trip blanking time enters trip state
// - Trip holds switches off, fault high for trip hold time, then resumes
// - Open shunt reads high and trips like any overcurrent
// - Temperature flag over trip point shuts all switches off
// - Thermal release after hysteresis drop; fault high during shutdown
// - Hall code unchanged for lock detect time activates lock protection
// - Lock protection holds switches off, fault high for lock hold time
// - Fault high while rotation opposes selected direction, low otherwise
// - Reverse rotation switches to trapezoidal before 60 degrees more rotation
// - Sinusoidal when rotation matches direction select, trapezoidal otherwise
// - All Hall signals high or all low flags abnormality, switches off
// - Other Hall codes drive switches per commutation truth tables
// - Fault stays high while Hall abnormality persists
// - Fault low in normal operation with no protection active
// - Forward trapezoidal table maps six Hall codes to switch pairs
`timescale 1ns/100ps
`include "mfp_regs.svh"
module mfp_top
  import mfp_pkg::*;
#(
  parameter int LIMIT_BLANK_CYC = `MFP_LIMIT_BLANK_CYC,
  parameter int TRIP_BLANK_CYC = `MFP_TRIP_BLANK_CYC,
  parameter int TRIP_HOLD_CYC = `MFP_TRIP_HOLD_CYC,
  parameter int LOCK_DETECT_CYC = `MFP_LOCK_DETECT_CYC,
  parameter int LOCK_HOLD_CYC = `MFP_LOCK_HOLD_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Analog comparator flags and Hall inputs
  input wire logic limit_threshold_i,
  input wire logic trip_threshold_i,
  input wire logic thermal_trip_temp_i,
  input wire logic thermal_hysteresis_i,
  input wire logic hall_pos_u_i,
  input wire logic hall_pos_v_i,
  input wire logic hall_pos_w_i,
  input wire logic direction_select_i,
  // Start of PWM period, same clock domain
  input wire logic pwm_period_start_i,
  // Sinusoidal engine gate demands: uh,ul,vh,vl,wh,wl
  input wire logic [5:0] sine_gates_i,
  output logic [5:0] gates_o,
  output logic trapezoidal_o,
  output logic fault_out_o
);
  // ==========================================
  // Input synchronisers
  // ==========================================
  logic [7:0] raw_in;
  logic [7:0] sync_in;
  assign raw_in = {direction_select_i, hall_pos_w_i, hall_pos_v_i, hall_pos_u_i,
                   thermal_hysteresis_i, thermal_trip_temp_i, trip_threshold_i, limit_threshold_i};
  mfp_sync #(.WIDTH(8)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(raw_in),
    .sync_o(sync_in)
  );
  wire logic lim_s = sync_in[0];
  wire logic trip_s = sync_in[1];
  wire logic hot_s = sync_in[2];
  wire logic cool_s = sync_in[3];
  wire logic [2:0] hall = {sync_in[4], sync_in[5], sync_in[6]};
  wire logic dir_pin_s = sync_in[7];

  // ==========================================
  // Registers
  // ==========================================
  logic [31:0] ctrl;
  logic [2:0] hall_prev;
  logic rev_rot;
  logic limit_off;
  logic therm_off;
  mfp_state_type state;
  mfp_state_type next_state;
  wire logic dir_sel = dir_pin_s ^ ctrl[`MFP_CTRL_DIR_BIT];
  wire logic lock_en = ctrl[`MFP_CTRL_LOCK_EN_BIT];

  // ==========================================
  // Hall decode and rotation sense
  // ==========================================
  wire logic hall_bad = (hall == 3'b111) || (hall == 3'b000);
  wire logic hall_step = (hall != hall_prev) && !hall_bad;
  // Forward order 101,100,110,010,011,001
  function automatic logic [2:0] fwd_next(input logic [2:0] h);
    case (h)
      3'b101: fwd_next = 3'b100;
      3'b100: fwd_next = 3'b110;
      3'b110: fwd_next = 3'b010;
      3'b010: fwd_next = 3'b011;
      3'b011: fwd_next = 3'b001;
      3'b001: fwd_next = 3'b101;
      default: fwd_next = 3'b000;
    endcase
  endfunction
  wire logic step_fwd = hall_step && (fwd_next(hall_prev) == hall);
  wire logic step_rev = hall_step && (fwd_next(hall) == hall_prev);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hall_prev <= 3'b000;
      rev_rot <= 1'b0;
    end else begin
      if (!hall_bad) begin
        hall_prev <= hall;
      end
      // Decided on the very edge, well inside 60 degrees
      if (step_fwd) begin
        rev_rot <= dir_sel;
      end else if (step_rev) begin
        rev_rot <= !dir_sel;
      end
    end
  end
  wire logic trap_mode = rev_rot;

  // ==========================================
  // Trapezoidal tables, reverse mirrors forward
  // ==========================================
  function automatic mfp_gates_type trap_fwd(input logic [2:0] h);
    case (h)
      3'b101: trap_fwd = 6'b01_10_00;
      3'b100: trap_fwd = 6'b01_00_10;
      3'b110: trap_fwd = 6'b00_01_10;
      3'b010: trap_fwd = 6'b10_01_00;
      3'b011: trap_fwd = 6'b10_00_01;
      3'b001: trap_fwd = 6'b00_10_01;
      default: trap_fwd = 6'b00_00_00;
    endcase
  endfunction
  // Hall vector is already in table order {u,v,w}
  wire logic [2:0] huvw = hall;
  wire logic [5:0] trap_gates = dir_sel ? trap_fwd(~huvw) : trap_fwd(huvw);
  wire logic [5:0] drive_gates = trap_mode ? trap_gates : sine_gates_i;

  // ==========================================
  // Current limit and trip
  // ==========================================
  logic lim_done;
  logic trip_done;
  logic lock_done;
  logic hold_done;
  mfp_timer #(.WIDTH(32)) u_lim_blank (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(lim_s),
    .limit_i(32'(LIMIT_BLANK_CYC - 1)),
    .done_o(lim_done)
  );
  // Open shunt holds the input high, so it lands here too
  mfp_timer #(.WIDTH(32)) u_trip_blank (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(trip_s),
    .limit_i(32'(TRIP_BLANK_CYC - 1)),
    .done_o(trip_done)
  );
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      limit_off <= 1'b0;
    end else if (lim_done) begin
      limit_off <= 1'b1;
    end else if (pwm_period_start_i) begin
      limit_off <= 1'b0;
    end
  end

  // ==========================================
  // Thermal shutdown with hysteresis
  // ==========================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      therm_off <= 1'b0;
    end else if (hot_s) begin
      therm_off <= 1'b1;
    end else if (cool_s) begin
      therm_off <= 1'b0;
    end
  end

  // ==========================================
  // Lock detect and hold sequencer
  // ==========================================
  wire logic lock_watch = lock_en && (state == MFP_RUN) && !hall_step && !hall_bad;
  mfp_timer #(.WIDTH(32)) u_lock_det (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(lock_watch),
    .limit_i(32'(LOCK_DETECT_CYC - 1)),
    .done_o(lock_done)
  );
  wire logic holding = (state != MFP_RUN);
  wire logic [31:0] hold_len = (state == MFP_LOCK_HOLD) ? 32'(LOCK_HOLD_CYC - 1) : 32'(TRIP_HOLD_CYC - 1);
  mfp_timer #(.WIDTH(32)) u_hold (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(holding),
    .limit_i(hold_len),
    .done_o(hold_done)
  );
  always_comb begin
    next_state = state;
    case (state)
      MFP_RUN: begin
        if (trip_done) begin
          next_state = MFP_TRIP_HOLD;
        end else if (lock_done) begin
          next_state = MFP_LOCK_HOLD;
        end
      end
      MFP_TRIP_HOLD: begin
        if (hold_done) begin
          next_state = MFP_RUN;
        end
      end
      MFP_LOCK_HOLD: begin
        if (hold_done) begin
          next_state = MFP_RUN;
        end
      end
      default: next_state = MFP_RUN;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= MFP_RUN;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================
  // Outputs
  // ==========================================
  wire logic shutoff = limit_off || therm_off || holding || hall_bad;
  wire logic fault = (state != MFP_RUN) || therm_off || hall_bad || rev_rot;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gates_o <= 6'h00;
      fault_out_o <= 1'b0;
      trapezoidal_o <= 1'b0;
    end else begin
      // Registered so a glitchy decode never reaches a gate
      gates_o <= shutoff ? 6'h00 : drive_gates;
      fault_out_o <= fault;
      trapezoidal_o <= trap_mode;
    end
  end

  // ==========================================
  // Wishbone slave
  // ==========================================
  wire logic wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic sel_ctrl = (wb_adr_i == `MFP_CTRL_ADDR);
  wire logic sel_stat = (wb_adr_i == `MFP_STAT_ADDR);
  wire logic [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire logic [31:0] stat_word = {24'h000000, fault_out_o, trap_mode, hall_bad, rev_rot,
                                 state == MFP_LOCK_HOLD, therm_off, state == MFP_TRIP_HOLD, limit_off};
  wire logic [31:0] rd_word = sel_ctrl ? ctrl : (sel_stat ? stat_word : 32'h00000000);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `MFP_CTRL_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        wb_dat_o <= rd_word;
      end
      if (wb_req && wb_we_i && sel_ctrl) begin
        ctrl <= ((ctrl & ~wmask) | (wb_dat_i & wmask)) & 32'h00000003;
      end
    end
  end

  // ==========================================
  // Checks
  // ==========================================
  hall_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hall_bad |=> (gates_o == 6'h00) && fault_out_o)
    else $error("Gates on during bad hall code");
  trip_enter_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == MFP_RUN) && trip_done |=> (state == MFP_TRIP_HOLD))
    else $error("Trip not entered");
  trip_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(state == MFP_TRIP_HOLD) |=> fault_out_o && (gates_o == 6'h00))
    else $error("Trip hold not driving fault");
  limit_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    lim_done |=> limit_off ##1 (gates_o == 6'h00))
    else $error("Limit did not cut gates");
  limit_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pwm_period_start_i && !lim_done |=> !limit_off)
    else $error("Limit not released at period start");
  therm_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hot_s |=> therm_off ##1 (fault_out_o && gates_o == 6'h00))
    else $error("Thermal shutdown missed");
  lock_enter_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == MFP_RUN) && lock_done && !trip_done |=> (state == MFP_LOCK_HOLD))
    else $error("Lock hold not entered");
  idle_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !holding && !therm_off && !hall_bad && !rev_rot |=> !fault_out_o)
    else $error("Fault high with nothing active");
endmodule
